// *** core/frwl_pkg.sv ***
// Constants, register map and types for the flash row write latch controller
// What this block does, and what its software must do
// [RQ1] Program start never erases any location
// [RQ2] One program writes at most 32 latches
// [RQ3] Upper ten address bits row, low five latch
// [RQ4] Program stays inside the addressed row
// [RQ5] All latches blank after program or erase
// [RQ6] Latch-only set: unlock loads latch only
// [RQ7] Latch-only clear: load latch, program all
// [RQ8] Interrupted unlock loads nothing, programs nothing
// [RQ9] Erase acts on one whole row
// [RQ10] Software sets enable, clears config, sets latch-only
// [RQ11] Software increments address, clears latch-only last
// [RQ12] Software copies row to RAM before modify
// [RQ13] Unlock is 55h, AAh, then write-control set
// [RQ14] Two forced idle cycles, then stall 2 ms
// [RQ15] Enable clear inhibits all program and erase
// [RQ16] Write-control set by software, cleared by hardware
// [RQ17] Any other access restarts the unlock detector
package frwl_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LOW_OFS   = 8'h00; // flash_addr_low
    localparam logic [7:0] ADDR_HIGH_OFS  = 8'h04; // flash_addr_high
    localparam logic [7:0] WORD_LOW_OFS   = 8'h08; // flash_word_low
    localparam logic [7:0] WORD_HIGH_OFS  = 8'h0C; // flash_word_high
    localparam logic [7:0] CONTROL_OFS    = 8'h10; // flash_control_one
    localparam logic [7:0] UNLOCK_OFS     = 8'h14; // flash_unlock_key

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CFG_BIT   = 6; // config_space_select
    localparam int LWO_BIT   = 5; // latch_only_select
    localparam int ERASE_BIT = 4;
    localparam int ENA_BIT   = 2; // program_erase_enable
    localparam int WRC_BIT   = 1; // write control
    localparam int BUSY_BIT  = 8; // stall status, read only

    // ------------------------------------------------------------
    // Geometry, keys and values
    // ------------------------------------------------------------
    localparam int          LATCH_CNT   = 32;
    localparam int          WORD_W      = 14;
    localparam int          IDX_W       = 5;
    localparam int          ROW_W       = 10;
    localparam logic [13:0] BLANK_WORD  = 14'h3FFF;
    localparam logic [7:0]  KEY_FIRST   = 8'h55;
    localparam logic [7:0]  KEY_SECOND  = 8'hAA;
    localparam logic [7:0]  CTRL_RESET  = 8'h80; // Bit 7 reads as one
    localparam logic [7:0]  ADRH_FILL   = 8'h80; // Bit 7 reads as one

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 50_000_000;
    localparam int STALL_US      = 2000;      // 2 ms typical program/erase
    localparam int STALL_CYCLES  = (CLK_HZ / 1_000_000) * STALL_US;
    localparam int IDLE_CYCLES   = 2;         // Forced no-operation cycles

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SEQ_IDLE  = 4'b0001,
        SEQ_FORCE = 4'b0010,
        SEQ_STALL = 4'b0100,
        SEQ_CLEAR = 4'b1000
    } frwl_seq_t;

    typedef struct packed {
        logic [ROW_W-1:0]  row;
        logic              erase;
        logic              valid;
    } frwl_op_t;

endpackage : frwl_pkg

// *** core/frwl_unlock.sv ***
// Unlock key detector for the flash row write latch controller
`timescale 1ns/1ps
module frwl_unlock
    import frwl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clkEn,
    input  wire logic       access,
    input  wire logic       keyWrite,
    input  wire logic [7:0] keyData,
    input  wire logic       wrcSet,
    output logic            unlocked
);
    logic [1:0] stage_reg;
    logic [1:0] stage_next;

    // ------------------------------------------------------------
    // Key stage tracking
    // ------------------------------------------------------------
    // Any access that is not the expected next step restarts
    always_comb
    begin
        stage_next = stage_reg;
        unlocked   = 1'b0;
        if (access)
        begin
            stage_next = 2'd0; // RQ17
            if (keyWrite && keyData == KEY_FIRST && stage_reg == 2'd0)
                stage_next = 2'd1; // RQ13
            else if (keyWrite && keyData == KEY_SECOND && stage_reg == 2'd1)
                stage_next = 2'd2; // RQ13
            else if (wrcSet && stage_reg == 2'd2)
                unlocked = 1'b1; // RQ13
            else if (keyWrite && keyData == KEY_FIRST)
                stage_next = 2'd1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            stage_reg <= 2'd0;
        else if (clkEn)
            stage_reg <= stage_next;
    end

    // Second key only counts straight after the first
    a_key_order: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && access && stage_reg == 2'd0 |=> stage_reg != 2'd2)
        else $error("second key stage reached without first key"); // RQ17

endmodule : frwl_unlock

// *** core/frwl_ctrl.sv ***
// Flash row write latch controller with Wishbone register slave
`timescale 1ns/1ps
module frwl_ctrl
    import frwl_pkg::*;
#(
    parameter int STALL_LEN = STALL_CYCLES
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clkEn,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatW,
    output logic [31:0]      wbDatR,
    output logic             wbAck,
    output logic             cpuStall,
    output logic             flashWrite,
    output logic             flashErase,
    output logic [9:0]       flashRow,
    output logic [4:0]       flashIdx,
    output logic [13:0]      flashData
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]        adrLow_reg,  adrLow_next;
    logic [6:0]        adrHigh_reg, adrHigh_next;
    logic [7:0]        datLow_reg,  datLow_next;
    logic [5:0]        datHigh_reg, datHigh_next;
    logic              cfg_reg,  cfg_next;
    logic              lwo_reg,  lwo_next;
    logic              ers_reg,  ers_next;
    logic              ena_reg,  ena_next;
    logic              wrc_reg,  wrc_next;
    logic [WORD_W-1:0] latch_reg [LATCH_CNT];
    frwl_seq_t         seq_reg,  seq_next;
    logic [31:0]       cnt_reg,  cnt_next;
    frwl_op_t          op_reg,   op_next;
    logic [IDX_W:0]    pgm_reg,  pgm_next;
    logic [31:0]       rdat_reg, rdat_next;
    logic              ack_reg,  ack_next;
    logic              stall_reg, stall_next;
    logic              fw_reg, fw_next, fe_reg, fe_next;
    logic [4:0]        fi_reg, fi_next;
    logic [13:0]       fd_reg, fd_next;

    logic              req, wr, unlocked, wrcSet, latchLoad, latchBlank;
    logic [IDX_W-1:0]  latchIdx;
    logic [ROW_W-1:0]  rowSel;

    assign req      = wbCyc && wbStb && !ack_reg;
    assign wr       = req && wbWe && wbSel[0];
    assign wrcSet   = wr && wbAdr == CONTROL_OFS && wbDatW[WRC_BIT];
    assign rowSel   = {adrHigh_reg, adrLow_reg[7:5]}; // RQ3
    assign latchIdx = adrLow_reg[4:0]; // RQ3

    // ------------------------------------------------------------
    // Unlock detector sees every accepted access
    // ------------------------------------------------------------
    frwl_unlock u_unlock (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .clkEn    (clkEn),
        .access   (req),
        .keyWrite (wr && wbAdr == UNLOCK_OFS),
        .keyData  (wbDatW[7:0]),
        .wrcSet   (wrcSet),
        .unlocked (unlocked)
    );

    // Latch action only on a complete unlock with writes enabled
    always_comb
    begin
        latchLoad = unlocked && ena_reg && !ers_reg && !cfg_reg && seq_reg == SEQ_IDLE; // RQ6 RQ8 RQ15
        latchBlank = seq_reg == SEQ_CLEAR; // RQ5
    end

    // ------------------------------------------------------------
    // Register file and bus answer
    // ------------------------------------------------------------
    always_comb
    begin
        adrLow_next  = adrLow_reg;
        adrHigh_next = adrHigh_reg;
        datLow_next  = datLow_reg;
        datHigh_next = datHigh_reg;
        cfg_next     = cfg_reg;
        lwo_next     = lwo_reg;
        ers_next     = ers_reg;
        ena_next     = ena_reg;
        ack_next     = req;
        rdat_next    = 32'h0000_0000;
        if (wr && seq_reg == SEQ_IDLE)
        begin
            case (wbAdr)
                ADDR_LOW_OFS:  adrLow_next  = wbDatW[7:0];
                ADDR_HIGH_OFS: adrHigh_next = wbDatW[6:0];
                WORD_LOW_OFS:  datLow_next  = wbDatW[7:0];
                WORD_HIGH_OFS: datHigh_next = wbDatW[5:0];
                CONTROL_OFS:
                begin
                    cfg_next = wbDatW[CFG_BIT];
                    lwo_next = wbDatW[LWO_BIT];
                    ers_next = wbDatW[ERASE_BIT];
                    ena_next = wbDatW[ENA_BIT];
                end
                default: ;
            endcase
        end
        if (seq_reg == SEQ_CLEAR && op_reg.erase)
            ers_next = 1'b0; // Erase select is hardware cleared
        if (req && !wbWe)
        begin
            case (wbAdr)
                ADDR_LOW_OFS:  rdat_next = {24'h000000, adrLow_reg};
                ADDR_HIGH_OFS: rdat_next = {24'h000000, ADRH_FILL | {1'b0, adrHigh_reg}};
                WORD_LOW_OFS:  rdat_next = {24'h000000, datLow_reg};
                WORD_HIGH_OFS: rdat_next = {26'h0000000, datHigh_reg};
                CONTROL_OFS:   rdat_next = {23'h000000, seq_reg != SEQ_IDLE, CTRL_RESET
                                   | {1'b0, cfg_reg, lwo_reg, ers_reg, 1'b0, ena_reg, wrc_reg, 1'b0}};
                default:       rdat_next = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // ------------------------------------------------------------
    // Program and erase sequencer
    // ------------------------------------------------------------
    // Stall and write-control are held until the self-timed step ends
    always_comb
    begin
        seq_next = seq_reg;
        cnt_next = cnt_reg;
        op_next  = op_reg;
        wrc_next = wrc_reg;
        pgm_next = pgm_reg;
        fw_next  = 1'b0;
        fe_next  = 1'b0;
        fi_next  = fi_reg;
        fd_next  = fd_reg;
        case (seq_reg)
            SEQ_IDLE:
            begin
                if (unlocked && ena_reg && !cfg_reg) // RQ15
                begin
                    wrc_next      = 1'b1; // RQ16
                    seq_next      = SEQ_FORCE; // RQ14
                    cnt_next      = 32'(IDLE_CYCLES - 1);
                    op_next.row   = rowSel; // RQ4
                    op_next.erase = ers_reg; // RQ9
                    op_next.valid = ers_reg || !lwo_reg; // RQ6 RQ7
                end
            end
            SEQ_FORCE:
            begin
                if (cnt_reg == 32'h0)
                begin
                    seq_next = op_reg.valid ? SEQ_STALL : SEQ_CLEAR;
                    cnt_next = 32'(STALL_LEN - 1);
                    pgm_next = '0;
                    fe_next  = op_reg.valid && op_reg.erase; // RQ9 whole row
                end
                else
                    cnt_next = cnt_reg - 32'h1;
            end
            SEQ_STALL:
            begin
                // Stream latch words into the row, never erase first
                if (!op_reg.erase && pgm_reg < 6'(LATCH_CNT)) // RQ1 RQ2
                begin
                    fw_next  = 1'b1;
                    fi_next  = pgm_reg[IDX_W-1:0];
                    fd_next  = latch_reg[pgm_reg[IDX_W-1:0]];
                    pgm_next = pgm_reg + 6'h1;
                end
                if (cnt_reg == 32'h0)
                    seq_next = SEQ_CLEAR;
                else
                    cnt_next = cnt_reg - 32'h1;
            end
            SEQ_CLEAR:
            begin
                wrc_next = 1'b0; // RQ16
                seq_next = SEQ_IDLE;
            end
            default: seq_next = SEQ_IDLE;
        endcase
        // Registered so the CPU hold never glitches on a state decode
        stall_next = seq_next != SEQ_IDLE; // RQ14
    end

    // Latch-only load leaves latches; program or erase blanks them
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            for (int i = 0; i < LATCH_CNT; i++)
                latch_reg[i] <= BLANK_WORD;
        end
        else if (clkEn)
        begin
            if (latchBlank && op_reg.valid)
            begin
                for (int i = 0; i < LATCH_CNT; i++)
                    latch_reg[i] <= BLANK_WORD; // RQ5
            end
            else if (latchLoad)
                latch_reg[latchIdx] <= {datHigh_reg, datLow_reg}; // RQ6 RQ7
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            adrLow_reg <= 8'h00;
            adrHigh_reg <= 7'h00;
            datLow_reg <= 8'h00;
            datHigh_reg <= 6'h00;
            cfg_reg <= 1'b0;
            lwo_reg <= 1'b0;
            ers_reg <= 1'b0;
            ena_reg <= 1'b0;
            wrc_reg <= 1'b0;
            seq_reg <= SEQ_IDLE;
            cnt_reg <= 32'h0;
            op_reg <= '0;
            pgm_reg <= '0;
            rdat_reg <= 32'h0;
            ack_reg <= 1'b0;
            stall_reg <= 1'b0;
            fw_reg <= 1'b0;
            fe_reg <= 1'b0;
            fi_reg <= 5'h00;
            fd_reg <= 14'h0000;
        end
        else if (clkEn)
        begin
            adrLow_reg <= adrLow_next;
            adrHigh_reg <= adrHigh_next;
            datLow_reg <= datLow_next;
            datHigh_reg <= datHigh_next;
            cfg_reg <= cfg_next;
            lwo_reg <= lwo_next;
            ers_reg <= ers_next;
            ena_reg <= ena_next;
            wrc_reg <= wrc_next;
            seq_reg <= seq_next;
            cnt_reg <= cnt_next;
            op_reg <= op_next;
            pgm_reg <= pgm_next;
            rdat_reg <= rdat_next;
            ack_reg <= ack_next;
            stall_reg <= stall_next;
            fw_reg <= fw_next;
            fe_reg <= fe_next;
            fi_reg <= fi_next;
            fd_reg <= fd_next;
        end
    end

    // Outputs straight from flip-flops
    assign wbDatR     = rdat_reg;
    assign wbAck      = ack_reg;
    assign cpuStall   = stall_reg; // RQ14
    assign flashWrite = fw_reg;
    assign flashErase = fe_reg;
    assign flashRow   = op_reg.row;
    assign flashIdx   = fi_reg;
    assign flashData  = fd_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_unlock_go;
        clkEn && unlocked && ena_reg && !cfg_reg && seq_reg == SEQ_IDLE;
    endsequence

    a_force_idle: assert property (@(posedge clk_sys) disable iff (rst)
        s_unlock_go |=> cpuStall && wrc_reg) // RQ14
        else $error("stall or write-control missing after unlock");
    a_no_enable: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && unlocked && !ena_reg && seq_reg == SEQ_IDLE |=> !cpuStall) // RQ15
        else $error("operation started with writes disabled");
    a_wrc_hold: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(wrc_reg) |-> $past(seq_reg) == SEQ_CLEAR) // RQ16
        else $error("write-control cleared outside completion");
    a_no_unlock: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && !unlocked && seq_reg == SEQ_IDLE |=> !cpuStall) // RQ8
        else $error("operation started without unlock");
    a_erase_noprog: assert property (@(posedge clk_sys) disable iff (rst)
        op_reg.erase |-> !flashWrite) // RQ1
        else $error("word written during erase");
    a_prog_count: assert property (@(posedge clk_sys) disable iff (rst)
        pgm_reg <= 6'(LATCH_CNT)) // RQ2
        else $error("more words than latches programmed");
    a_row_fixed: assert property (@(posedge clk_sys) disable iff (rst)
        seq_reg == SEQ_STALL && $past(seq_reg) == SEQ_STALL |-> $stable(flashRow)) // RQ4
        else $error("row changed during program");
    a_latch_blank: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && latchBlank && op_reg.valid |=> latch_reg[latchIdx] == BLANK_WORD) // RQ5
        else $error("latch not blank after operation");
    a_latch_only: assert property (@(posedge clk_sys) disable iff (rst)
        s_unlock_go ##0 lwo_reg && !ers_reg |=> ##2 seq_reg == SEQ_CLEAR) // RQ6
        else $error("latch-only unlock did not skip programming");

endmodule : frwl_ctrl

// *** verification/tb_flash_row_write_latch_control.sv ***
// Self-checking testbench for the flash row write latch controller
`timescale 1ns/1ps
module tb_flash_row_write_latch_control
    import frwl_pkg::*;
;
    // ------------------------------------------------------------
    // Settings and signals
    // ------------------------------------------------------------
    localparam int         STALL_SIM = 40;     // Short stall keeps the run brief
    localparam int         WAIT_MAX  = 300;
    localparam logic [7:0] C_LATCH   = 8'h24;  // Enable plus latch-only
    localparam logic [7:0] C_PROG    = 8'h04;  // Enable, row program
    localparam logic [7:0] C_ERASE   = 8'h14;  // Enable, row erase

    logic        clk_sys;
    logic        rst;
    logic        clkEn;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [7:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatW;
    logic [31:0] wbDatR;
    logic        wbAck;
    logic        cpuStall;
    logic        flashWrite;
    logic        flashErase;
    logic [9:0]  flashRow;
    logic [4:0]  flashIdx;
    logic [13:0] flashData;
    int          bad_count;
    int          checked;
    int          seed;
    int          latchModel [LATCH_CNT];
    logic [28:0] writeQ [$];
    logic [9:0]  eraseQ [$];
    logic [31:0] rd;

    frwl_ctrl #(.STALL_LEN(STALL_SIM)) u_frwl_ctrl (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .clkEn      (clkEn),
        .wbCyc      (wbCyc),
        .wbStb      (wbStb),
        .wbWe       (wbWe),
        .wbAdr      (wbAdr),
        .wbSel      (wbSel),
        .wbDatW     (wbDatW),
        .wbDatR     (wbDatR),
        .wbAck      (wbAck),
        .cpuStall   (cpuStall),
        .flashWrite (flashWrite),
        .flashErase (flashErase),
        .flashRow   (flashRow),
        .flashIdx   (flashIdx),
        .flashData  (flashData)
    );

    // Free-running system clock, 20 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Collect flash strobes mid-cycle, where registered outputs are settled
    always @(negedge clk_sys)
    begin
        if (flashWrite === 1'b1)
            writeQ.push_back({flashRow, flashIdx, flashData});
        if (flashErase === 1'b1)
            eraseQ.push_back(flashRow);
    end

    // ------------------------------------------------------------
    // Reporting and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // Classic single cycle; ack and read data are taken at the edge sampling ack high
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dw,
                        output logic [31:0] dr);
        int n;
        n = 0;
        @(posedge clk_sys);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= adr;
        wbSel  <= 4'h1;
        wbDatW <= dw;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wbAck !== 1'b1 && n < WAIT_MAX);
        dr = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= WAIT_MAX)
        begin
            check(1'b0, "bus timeout");
            conclude();
        end
    endtask : xfer

    task automatic wr(input logic [7:0] adr, input logic [7:0] v);
        logic [31:0] d;
        xfer(1'b1, adr, {24'h000000, v}, d);
    endtask : wr

    task automatic rdr(input logic [7:0] adr, output logic [31:0] d);
        xfer(1'b0, adr, 32'h00000000, d);
    endtask : rdr

    // Counts cycles the CPU is still held once the unlock write has been acked
    task automatic waitIdle(output int n);
        n = 0;
        @(negedge clk_sys);
        while (cpuStall !== 1'b0 && n < WAIT_MAX)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= WAIT_MAX)
        begin
            check(1'b0, "stall timeout");
            conclude();
        end
    endtask : waitIdle

    task automatic unlockRun(input logic [7:0] ctrl, output int n);
        wr(UNLOCK_OFS, KEY_FIRST);
        wr(UNLOCK_OFS, KEY_SECOND);
        wr(CONTROL_OFS, ctrl | 8'h02);
        waitIdle(n);
    endtask : unlockRun

    task automatic loadWord(input logic [9:0] row, input logic [4:0] idx, input logic [13:0] w);
        wr(ADDR_LOW_OFS, {row[2:0], idx});
        wr(ADDR_HIGH_OFS, {1'b0, row[9:3]});
        wr(WORD_LOW_OFS, w[7:0]);
        wr(WORD_HIGH_OFS, {2'b00, w[13:8]});
    endtask : loadWord

    // Whole row must come out in index order, then the model latches go blank
    task automatic checkProgram(input logic [9:0] row);
        logic [28:0] e;
        check(writeQ.size() == LATCH_CNT, "program word count");
        check(eraseQ.size() == 0, "erase pulse during program");
        for (int i = 0; i < LATCH_CNT; i++)
        begin
            e = {row, i[4:0], latchModel[i][13:0]};
            if (i < writeQ.size())
                check(writeQ[i] === e, "programmed word mismatch");
            latchModel[i] = BLANK_WORD;
        end
        writeQ.delete();
    endtask : checkProgram

    // Watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        check(1'b0, "run timeout");
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        int          n;
        logic [9:0]  row;
        logic [4:0]  idx;
        logic [13:0] w;
        logic [7:0]  ctl;
        seed = 32'h77b9;
        bad_count = 0;
        checked = 0;
        rst = 1'b1;
        clkEn = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h1;
        wbDatW = 32'h00000000;
        foreach (latchModel[i]) latchModel[i] = BLANK_WORD;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rdr(CONTROL_OFS, rd);
        check(rd[7:0] === CTRL_RESET, "control reset value");
        rdr(ADDR_HIGH_OFS, rd);
        check(rd[7:0] === ADRH_FILL, "address high reset value");
        rdr(8'h20, rd);
        check(rd === 32'h00000000, "unmapped read not zero");
        $display("test reset done");
        // Scattered latch-only loads, then the last word starts the program
        row = 10'($random(seed));
        wr(CONTROL_OFS, C_LATCH);
        repeat (6)
        begin
            idx = 5'($random(seed));
            w = 14'($random(seed));
            loadWord(row, idx, w);
            unlockRun(C_LATCH, n);
            latchModel[idx] = w;
            check(writeQ.size() == 0 && n <= IDLE_CYCLES, "latch-only load");
        end
        wr(CONTROL_OFS, C_PROG);
        w = 14'($random(seed));
        loadWord(row, 5'h1F, w);
        unlockRun(C_PROG, n);
        latchModel[31] = w;
        check(n >= STALL_SIM - 2 && n <= STALL_SIM + 6, "program stall length");
        checkProgram(row);
        rdr(CONTROL_OFS, rd);
        check(rd[1] === 1'b0, "write control not cleared");
        $display("test row program done");
        // One word alone: every other latch must still be blank
        row = row + 10'h001;
        idx = 5'($random(seed));
        w = 14'($random(seed));
        loadWord(row, idx, w);
        wr(UNLOCK_OFS, KEY_FIRST);
        wr(UNLOCK_OFS, KEY_SECOND);
        wr(CONTROL_OFS, C_PROG | 8'h02);
        // Freeze in the forced idle cycles: the stall must lengthen, not end early
        clkEn <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check(cpuStall === 1'b1 && writeQ.size() == 0, "state moved while frozen");
        clkEn <= 1'b1;
        waitIdle(n);
        latchModel[idx] = w;
        check(n >= STALL_SIM - 2 && n <= STALL_SIM + 6, "frozen stall length");
        checkProgram(row);
        $display("test blank latches done");
        // Broken unlock sequences must neither load nor program
        for (int k = 0; k < 3; k++)
        begin
            loadWord(row, 5'(k), 14'h0123);
            wr(UNLOCK_OFS, KEY_FIRST);
            if (k == 0) rdr(CONTROL_OFS, rd);
            if (k == 1) wr(WORD_LOW_OFS, 8'h5A);
            wr(UNLOCK_OFS, KEY_SECOND);
            if (k == 2) rdr(ADDR_LOW_OFS, rd);
            wr(CONTROL_OFS, C_PROG | 8'h02);
            waitIdle(n);
            check(n == 0 && writeQ.size() == 0, "interrupted unlock acted");
        end
        w = 14'($random(seed));
        loadWord(row, 5'd9, w);
        unlockRun(C_PROG, n);
        latchModel[9] = w;
        checkProgram(row);
        $display("test interrupted unlock done");
        // Enable clear, or config space selected, blocks everything
        for (int j = 0; j < 2; j++)
        begin
            ctl = (j == 0) ? 8'h00 : 8'h44;
            wr(CONTROL_OFS, ctl);
            loadWord(row, 5'd3, 14'h1111);
            unlockRun(ctl, n);
            check(n == 0 && writeQ.size() == 0 && eraseQ.size() == 0, "disabled op ran");
            rdr(CONTROL_OFS, rd);
            check(rd[1] === 1'b0, "write control set while disabled");
        end
        $display("test enable clear done");
        // Modify: erase the row, then reprogram it; a loaded latch is wiped
        wr(CONTROL_OFS, C_LATCH);
        loadWord(row, 5'd4, 14'h0A5A);
        unlockRun(C_LATCH, n);
        wr(CONTROL_OFS, C_ERASE);
        unlockRun(C_ERASE, n);
        check(eraseQ.size() == 1 && eraseQ[0] === row && writeQ.size() == 0, "row erase");
        eraseQ.delete();
        rdr(CONTROL_OFS, rd);
        check(rd[4] === 1'b0, "erase select not cleared");
        wr(CONTROL_OFS, C_PROG);
        w = 14'($random(seed));
        loadWord(row, 5'd20, w);
        unlockRun(C_PROG, n);
        latchModel[20] = w;
        checkProgram(row);
        $display("test erase done");
        conclude();
    end

endmodule : tb_flash_row_write_latch_control
